// file: include/fbh_cfg.svh
/*
 Constants for the parallel flash host controller: register offsets, field
 positions, reset values, command words and pin timing counts.
 Assumes a 200 MHz controller clock and a flash that is asynchronous.
*/
`ifndef FBH_CFG_SVH
`define FBH_CFG_SVH

`define FBH_CLK_NS 5
`define FBH_CYC(ns) (((ns) + `FBH_CLK_NS - 1) / `FBH_CLK_NS)
// Access time of the slowest speed grade, write pulse width, gap between cycles.
`define FBH_T_ACC_NS 90
`define FBH_T_WP_NS 35
`define FBH_T_GAP_NS 20
`define FBH_ACC_CYC `FBH_CYC(`FBH_T_ACC_NS)
`define FBH_WP_CYC `FBH_CYC(`FBH_T_WP_NS)
`define FBH_GAP_CYC `FBH_CYC(`FBH_T_GAP_NS)

`define FBH_REG_CTRL 8'h00
`define FBH_REG_CFG 8'h04
`define FBH_REG_ADDR 8'h08
`define FBH_REG_WDATA 8'h0C
`define FBH_REG_RDATA 8'h10
`define FBH_REG_STATUS 8'h14

`define FBH_CTRL_GO_BIT 0
`define FBH_CTRL_OP_LSB 1
`define FBH_CFG_WORD_BIT 0
`define FBH_CFG_WP_BIT 1
`define FBH_CFG_RST_BIT 2
`define FBH_CFG_RESET 3'h7
`define FBH_STAT_BUSY_BIT 0
`define FBH_STAT_ERR_BIT 1
`define FBH_STAT_BANK_LSB 2

// Unlock and program command words, word-mode addresses.
`define FBH_UNLOCK_A1 22'h000555
`define FBH_UNLOCK_D1 8'hAA
`define FBH_UNLOCK_A2 22'h0002AA
`define FBH_UNLOCK_D2 8'h55
`define FBH_PROG_CMD 8'hA0
`define FBH_BANK_LSB 20

`endif

// file: include/fbh_pkg.sv
/*
 Types shared by the parallel flash host controller modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package fbh_pkg;
	typedef enum logic [1:0] {
		fbh_op_read,
		fbh_op_write,
		fbh_op_prog,
		fbh_op_bprog
	} fbh_op_t;
endpackage

// file: hdl/fbh_cycle.sv
/*
 One pin-level bus cycle to the flash: a read or a single write.
 Assumes the caller holds its inputs stable from i_start until o_done.
*/
`timescale 1ns/1ps
`include "fbh_cfg.svh"
module fbh_cycle import fbh_pkg::*; (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_start,
	input wire logic i_write,
	input wire logic i_word_mode,
	input wire logic [22:0] i_addr,
	input wire logic [15:0] i_data,
	input wire logic [15:0] i_dq,
	output logic o_ce_n,
	output logic o_oe_n,
	output logic o_we_n,
	output logic [21:0] o_addr,
	output logic [15:0] o_dq,
	output logic [15:0] o_dq_oe,
	output logic [15:0] o_rdata,
	output logic o_done
);
	typedef enum logic [1:0] {st_idle, st_setup, st_strobe, st_hold} fbh_cyc_state_t;

	fbh_cyc_state_t state_r;
	logic write_r;
	logic [5:0] cnt_r;
	wire logic [15:0] oe_mask;
	wire logic [21:0] pin_addr;
	wire logic [15:0] pin_data;

	// In byte mode the top data line carries the byte-address bit and lines 14 to 8 stay undriven.
	assign oe_mask = i_word_mode ? (i_write ? 16'hFFFF : 16'h0000)
		: (i_write ? 16'h80FF : 16'h8000);
	assign pin_addr = i_word_mode ? i_addr[21:0] : i_addr[22:1];
	assign pin_data = i_word_mode ? i_data : {i_addr[0], 7'h00, i_data[7:0]};

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			state_r <= st_idle;
			write_r <= 1'b0;
			cnt_r <= 6'h00;
			o_ce_n <= 1'b1;
			o_oe_n <= 1'b1;
			o_we_n <= 1'b1;
			o_addr <= 22'h000000;
			o_dq <= 16'h0000;
			o_dq_oe <= 16'h0000;
			o_rdata <= 16'h0000;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			case (state_r)
				st_idle: begin
					if (i_start) begin
						write_r <= i_write;
						o_ce_n <= 1'b0;
						o_addr <= pin_addr;
						o_dq <= pin_data;
						o_dq_oe <= oe_mask;
						state_r <= st_setup;
					end
				end
				st_setup: begin
					// Only one of the two strobes ever falls, so the data bus is never fought over.
					if (write_r) begin
						o_we_n <= 1'b0;
						cnt_r <= 6'(`FBH_WP_CYC - 1);
					end else begin
						o_oe_n <= 1'b0;
						cnt_r <= 6'(`FBH_ACC_CYC - 1);
					end
					state_r <= st_strobe;
				end
				st_strobe: begin
					if (cnt_r == 6'h00) begin
						o_we_n <= 1'b1;
						o_oe_n <= 1'b1;
						if (!write_r) begin
							o_rdata <= i_word_mode ? i_dq : {8'h00, i_dq[7:0]};
						end
						cnt_r <= 6'(`FBH_GAP_CYC - 1);
						state_r <= st_hold;
					end else begin
						cnt_r <= cnt_r - 6'h01;
					end
				end
				st_hold: begin
					// Data stays driven past the rising write strobe to meet hold time.
					if (cnt_r == 6'h00) begin
						o_ce_n <= 1'b1;
						o_dq_oe <= 16'h0000;
						o_done <= 1'b1;
						state_r <= st_idle;
					end else begin
						cnt_r <= cnt_r - 6'h01;
					end
				end
				default: begin
					state_r <= st_idle;
				end
			endcase
		end
	end

	chk_write_levels: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		!o_we_n |-> (!o_ce_n && o_oe_n && o_dq_oe[7:0] == 8'hFF))
		else $error("write strobe low without chip select or with output gate low");
	chk_write_width: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		$fell(o_we_n) |-> (!o_we_n)[*7] ##1 o_we_n)
		else $error("write strobe pulse is not seven cycles long");
endmodule

// file: hdl/fbh_host.sv
/*
 Host controller for an asynchronous parallel NOR flash: software registers,
 single reads and writes, standard and bypass program sequences.
 Assumes the flash pins are wired directly and the data bus is resolved outside.
*/
// Chosen here: the placing of the registers and the plain strobed port.
// Behaviour
// - A read drives chip select and output gate low, write strobe high, hardware reset released.
// - A command write drives write strobe and chip select low with output gate high.
// - Program data is a byte or a word according to the width pin, and the host matches it.
// - In bypass mode a program takes two write cycles instead of four.
`timescale 1ns/1ps
`include "fbh_cfg.svh"
module fbh_host import fbh_pkg::*; (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rd_data,
	input wire logic [15:0] i_dq,
	output logic [15:0] o_dq,
	output logic [15:0] o_dq_oe,
	output logic [21:0] o_flash_addr,
	output logic o_ce_n,
	output logic o_oe_n,
	output logic o_we_n,
	output logic o_reset_n,
	output logic o_byte_n,
	output logic o_protect_accel_pin
);
	logic [2:0] cfg_r;
	logic [22:0] addr_r;
	logic [15:0] wdata_r;
	logic [15:0] rdata_r;
	fbh_op_t op_r;
	logic busy_r;
	logic err_r;
	logic [1:0] step_r;
	logic start_r;
	logic [2:0] we_cnt_r;
	logic we_q_r;
	wire logic word_mode;
	wire logic cyc_done;
	wire logic [15:0] cyc_rdata;
	wire logic [38:0] step_word;
	wire logic last_step;
	wire logic wr_ctrl;
	wire logic wr_cfg;
	wire logic go_req;
	wire logic go_ok;
	wire logic err_clr;
	wire logic err_set;
	wire logic [1:0] bank;
	logic [31:0] rd_mux;

	// Number of the final pin cycle of each operation.
	function automatic logic [1:0] fbh_last(input fbh_op_t op);
		case (op)
			fbh_op_prog: fbh_last = 2'h3;
			fbh_op_bprog: fbh_last = 2'h1;
			default: fbh_last = 2'h0;
		endcase
	endfunction

	// Turns a word-mode command address into the pin address for the current width.
	function automatic logic [22:0] fbh_cmd_addr(input logic [21:0] a, input logic wm);
		fbh_cmd_addr = wm ? {1'b0, a} : {a, 1'b0};
	endfunction

	// Address and data of one step of an operation, packed as {address, data}.
	function automatic logic [38:0] fbh_step(input fbh_op_t op, input logic [1:0] step,
		input logic [22:0] a, input logic [15:0] d, input logic wm);
		fbh_step = {a, d};
		if (op == fbh_op_prog) begin
			case (step)
				2'h0: fbh_step = {fbh_cmd_addr(`FBH_UNLOCK_A1, wm), 8'h00, `FBH_UNLOCK_D1};
				2'h1: fbh_step = {fbh_cmd_addr(`FBH_UNLOCK_A2, wm), 8'h00, `FBH_UNLOCK_D2};
				2'h2: fbh_step = {fbh_cmd_addr(`FBH_UNLOCK_A1, wm), 8'h00, `FBH_PROG_CMD};
				default: fbh_step = {a, d};
			endcase
		end else if (op == fbh_op_bprog && step == 2'h0) begin
			// Bypass skips both unlock cycles; the command word goes to the target address.
			fbh_step = {a, 8'h00, `FBH_PROG_CMD};
		end
	endfunction

	assign word_mode = cfg_r[`FBH_CFG_WORD_BIT];
	assign step_word = fbh_step(op_r, step_r, addr_r, wdata_r, word_mode);
	assign last_step = (step_r == fbh_last(op_r));
	assign wr_ctrl = i_wr && (i_addr == `FBH_REG_CTRL);
	assign wr_cfg = i_wr && (i_addr == `FBH_REG_CFG) && !busy_r;
	assign go_req = wr_ctrl && i_wr_data[`FBH_CTRL_GO_BIT];
	// A cycle while the flash is held in reset would be ignored, so it is refused here.
	assign go_ok = go_req && !busy_r && cfg_r[`FBH_CFG_RST_BIT];
	assign err_set = (go_req && !go_ok) || (i_wr && (i_addr == `FBH_REG_CFG) && busy_r);
	assign err_clr = i_wr && (i_addr == `FBH_REG_STATUS) && i_wr_data[`FBH_STAT_ERR_BIT];
	assign bank = word_mode ? addr_r[`FBH_BANK_LSB+1:`FBH_BANK_LSB]
		: addr_r[`FBH_BANK_LSB+2:`FBH_BANK_LSB+1];

	always_comb begin
		rd_mux = 32'h00000000;
		case (i_addr)
			`FBH_REG_CTRL: rd_mux = {29'h00000000, op_r, 1'b0};
			`FBH_REG_CFG: rd_mux = {29'h00000000, cfg_r};
			`FBH_REG_ADDR: rd_mux = {9'h000, addr_r};
			`FBH_REG_WDATA: rd_mux = {16'h0000, wdata_r};
			`FBH_REG_RDATA: rd_mux = {16'h0000, rdata_r};
			`FBH_REG_STATUS: rd_mux = {28'h0000000, bank, err_r, busy_r};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			o_rd_data <= 32'h00000000;
		end else begin
			o_rd_data <= i_rd ? rd_mux : 32'h00000000;
		end
	end

	// Width, protect and reset pins only change between operations so data width stays matched.
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			cfg_r <= `FBH_CFG_RESET;
			addr_r <= 23'h000000;
			wdata_r <= 16'h0000;
		end else begin
			if (wr_cfg) begin
				cfg_r <= i_wr_data[2:0];
			end
			if (i_wr && (i_addr == `FBH_REG_ADDR) && !busy_r) begin
				addr_r <= i_wr_data[22:0];
			end
			if (i_wr && (i_addr == `FBH_REG_WDATA) && !busy_r) begin
				wdata_r <= i_wr_data[15:0];
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			err_r <= 1'b0;
		end else if (err_set) begin
			err_r <= 1'b1;
		end else if (err_clr) begin
			err_r <= 1'b0;
		end
	end

	// Reads need no command first: the flash comes out of reset reading its array.
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			op_r <= fbh_op_read;
			busy_r <= 1'b0;
			step_r <= 2'h0;
			start_r <= 1'b0;
			rdata_r <= 16'h0000;
		end else begin
			start_r <= 1'b0;
			if (go_ok) begin
				op_r <= fbh_op_t'(i_wr_data[`FBH_CTRL_OP_LSB+1:`FBH_CTRL_OP_LSB]);
				busy_r <= 1'b1;
				step_r <= 2'h0;
				start_r <= 1'b1;
			end else if (busy_r && cyc_done) begin
				if (last_step) begin
					busy_r <= 1'b0;
					if (op_r == fbh_op_read) begin
						rdata_r <= cyc_rdata;
					end
				end else begin
					step_r <= step_r + 2'h1;
					start_r <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			o_reset_n <= 1'b0;
			o_byte_n <= 1'b1;
			o_protect_accel_pin <= 1'b0;
		end else begin
			o_reset_n <= cfg_r[`FBH_CFG_RST_BIT];
			o_byte_n <= cfg_r[`FBH_CFG_WORD_BIT];
			o_protect_accel_pin <= cfg_r[`FBH_CFG_WP_BIT];
		end
	end

	fbh_cycle u_cycle (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_start(start_r),
		.i_write(op_r != fbh_op_read),
		.i_word_mode(word_mode),
		.i_addr(step_word[38:16]),
		.i_data(step_word[15:0]),
		.i_dq(i_dq),
		.o_ce_n(o_ce_n),
		.o_oe_n(o_oe_n),
		.o_we_n(o_we_n),
		.o_addr(o_flash_addr),
		.o_dq(o_dq),
		.o_dq_oe(o_dq_oe),
		.o_rdata(cyc_rdata),
		.o_done(cyc_done)
	);

	// Counts write strobes of the running operation for the checks below.
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			we_cnt_r <= 3'h0;
			we_q_r <= 1'b1;
		end else begin
			we_q_r <= o_we_n;
			if (go_ok) begin
				we_cnt_r <= 3'h0;
			end else if (we_q_r && !o_we_n) begin
				we_cnt_r <= we_cnt_r + 3'h1;
			end
		end
	end

	chk_read_levels: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		!o_oe_n |-> (!o_ce_n && o_we_n && o_reset_n && o_dq_oe[7:0] == 8'h00))
		else $error("read cycle with wrong control levels or driven data");
	chk_read_hold: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		$fell(o_oe_n) |-> (!o_oe_n && !o_ce_n)[*8])
		else $error("output gate released too early in a read");
	chk_byte_lines: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(!o_byte_n && !o_ce_n) |-> (o_dq_oe[14:8] == 7'h00 && o_dq_oe[15]))
		else $error("byte mode drives upper data lines or drops the byte-address bit");
	chk_word_width: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(o_byte_n && !o_we_n) |-> o_dq_oe == 16'hFFFF)
		else $error("word-mode write not driving all sixteen lines");
	chk_bypass_count: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		($fell(busy_r) && op_r == fbh_op_bprog) |-> we_cnt_r == 3'h2)
		else $error("bypass program did not take two write cycles");
	chk_prog_count: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		($fell(busy_r) && op_r == fbh_op_prog) |-> we_cnt_r == 3'h4)
		else $error("standard program did not take four write cycles");
endmodule

// file: testbench/fbh_flash_model.sv
/*
 Behavioural model of the asynchronous NOR flash that the host controller drives.
 Assumes the bench resolves the shared data lines and feeds the resolved wire back in.
*/
`timescale 1ns/1ps
module fbh_flash_model (
	input wire logic i_ce_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic i_reset_n,
	input wire logic i_byte_n,
	input wire logic i_protect_accel_pin,
	input wire logic [21:0] i_addr,
	input wire logic [15:0] i_dq,
	output logic [15:0] o_dq
);
	logic [15:0] mem [int];
	logic [15:0] junk = 16'h5A5A;
	logic [15:0] cur;
	logic [7:0] cd;
	logic bypass = 1'b0;
	int step = 0;
	wire logic rd_on = !i_ce_n && !i_oe_n && i_we_n && i_reset_n;
	function automatic logic [15:0] peek(input logic [21:0] a);
		return mem.exists(a) ? mem[a] : 16'hFFFF;
	endfunction
	// Sectors are taken as uniform 32K-word blocks; the small boot sectors are lumped together.
	task automatic wipe(input logic [21:0] a, input bit all);
		int keys [$];
		foreach (mem[i])
			if ((all || i[21:15] == a[21:15])
				&& (i_protect_accel_pin || (i[21:13] != 9'h000 && i[21:13] != 9'h1FF)))
				keys.push_back(i);
		foreach (keys[j])
			mem.delete(keys[j]);
	endtask
	// Released lines toggle so that a stale value can never pass for read data.
	always #3 junk = ~junk;
	always @(junk, i_addr, i_dq, rd_on, i_byte_n) begin
		cur = peek(i_addr);
		if (!rd_on)
			o_dq = junk;
		else if (i_byte_n)
			o_dq = cur;
		else
			o_dq = {junk[15:8], (i_dq[15] ? cur[15:8] : cur[7:0])};
	end
	always @(negedge i_reset_n) begin
		step = 0;
		bypass = 1'b0;
	end
	// Commands are latched on the rising write strobe; sector and chip erase take effect at once.
	always @(posedge i_we_n) begin
		if (!i_ce_n && i_oe_n && i_reset_n) begin
			cd = i_dq[7:0];
			// Any word but another sector code closes the sector list and is taken as a new command.
			if (step == 8 && cd != 8'h30)
				step = 0;
			if (step == 3) begin
				step = 0;
				if (i_protect_accel_pin || (i_addr[21:13] != 9'h000 && i_addr[21:13] != 9'h1FF))
					mem[i_addr] = peek(i_addr) & (i_byte_n ? i_dq : (i_dq[15] ? {cd, 8'hFF} : {8'hFF, cd}));
			end else if (step == 4) begin
				step = 0;
				bypass = 1'b0;
			end else if (bypass && step == 0)
				step = (cd == 8'hA0) ? 3 : ((cd == 8'h90) ? 4 : 0);
			else if (step == 0)
				step = (cd == 8'hAA && i_addr[10:0] == 11'h555) ? 1 : 0;
			else if (step == 1)
				step = (cd == 8'h55 && i_addr[10:0] == 11'h2AA) ? 2 : 0;
			else if (step == 5)
				step = (cd == 8'hAA && i_addr[10:0] == 11'h555) ? 6 : 0;
			else if (step == 6)
				step = (cd == 8'h55 && i_addr[10:0] == 11'h2AA) ? 7 : 0;
			else if (step >= 7) begin
				if (cd == 8'h30)
					wipe(i_addr, 1'b0);
				else if (cd == 8'h10 && step == 7)
					wipe(i_addr, 1'b1);
				step = (cd == 8'h30) ? 8 : 0;
			end else begin
				bypass = (cd == 8'h20);
				step = (cd == 8'hA0) ? 3 : ((cd == 8'h80) ? 5 : 0);
			end
		end
	end
endmodule

// file: testbench/fbh_host_tb.sv
/*
 Self-checking bench for the parallel flash host controller against a flash model.
 Assumes the register map and command words of the shared configuration header.
*/
`timescale 1ns/1ps
`include "fbh_cfg.svh"
module fbh_host_tb;
	logic i_ref_clk, i_resetn, i_wr, i_rd;
	logic [7:0] i_addr;
	logic [31:0] i_wr_data, o_rd_data, q;
	logic [15:0] h_dq, h_oe, f_dq;
	wire logic [15:0] dq_w = (h_oe & h_dq) | (~h_oe & f_dq);
	logic [21:0] fa;
	logic ce_n, oe_n, we_n, frst_n, byte_n, wpin;
	logic [15:0] em [int];
	logic [22:0] a;
	logic [22:0] ea [3];
	logic wm = 1'b1, wp = 1'b1, byp = 1'b0;
	int err_total = 0, comparisons = 0, k;

	fbh_host uut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wr_data(i_wr_data),
		.i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_dq(dq_w), .o_dq(h_dq), .o_dq_oe(h_oe),
		.o_flash_addr(fa), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_reset_n(frst_n),
		.o_byte_n(byte_n), .o_protect_accel_pin(wpin));
	fbh_flash_model flash (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_reset_n(frst_n),
		.i_byte_n(byte_n), .i_protect_accel_pin(wpin), .i_addr(fa), .i_dq(dq_w), .o_dq(f_dq));

	initial begin
		i_ref_clk = 1'b0;
		forever #2.5 i_ref_clk = ~i_ref_clk;
	end
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
		@(posedge i_ref_clk);
		i_addr <= ad;
		i_wr_data <= dt;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, output logic [31:0] r);
		@(posedge i_ref_clk);
		i_addr <= ad;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 r = o_rd_data;
	endtask
	task automatic idle;
		int n;
		repeat (2) @(posedge i_ref_clk);
		for (n = 0; n < 100; n++) begin
			rd(`FBH_REG_STATUS, q);
			if (q[0] === 1'b0)
				return;
		end
		err_total++;
		$display("unexpected at %0t: busy never cleared", $time);
		wrap_up();
	endtask
	task automatic run(input logic [1:0] op);
		wr(`FBH_REG_CTRL, {29'h0, op, 1'b1});
		idle();
	endtask
	task automatic cfg(input logic r, input logic p, input logic m);
		wr(`FBH_REG_CFG, {29'h0, r, p, m});
		wp = p;
		wm = m;
	endtask
	function automatic logic [15:0] ex(input logic [21:0] w);
		return em.exists(w) ? em[w] : 16'hFFFF;
	endfunction
	// Flash bits only ever go from one to zero, so the expectation is an AND.
	task automatic pgm(input logic [22:0] ad, input logic [15:0] dt, input logic [1:0] op);
		logic [21:0] w;
		logic [15:0] m;
		w = wm ? ad[21:0] : ad[22:1];
		m = wm ? dt : (ad[0] ? {dt[7:0], 8'hFF} : {8'hFF, dt[7:0]});
		wr(`FBH_REG_ADDR, {9'h0, ad});
		wr(`FBH_REG_WDATA, {16'h0, dt});
		run(op);
		if ((op == 2'd2 || (op == 2'd3 && byp)) && (wp || (w[21:13] != 9'h000 && w[21:13] != 9'h1FF)))
			em[w] = ex(w) & m;
	endtask
	task automatic rchk(input logic [22:0] ad);
		logic [15:0] e;
		e = ex(wm ? ad[21:0] : ad[22:1]);
		wr(`FBH_REG_ADDR, {9'h0, ad});
		run(2'd0);
		rd(`FBH_REG_RDATA, q);
		chk(q, wm ? {16'h0, e} : {24'h0, (ad[0] ? e[15:8] : e[7:0])}, "array data");
	endtask
	// Unlock, erase set-up, unlock again; the caller adds the sector or chip code.
	task automatic erase_pre;
		pgm(23'h555, 16'hAA, 2'd1);
		pgm(23'h2AA, 16'h55, 2'd1);
		pgm(23'h555, 16'h80, 2'd1);
		pgm(23'h555, 16'hAA, 2'd1);
		pgm(23'h2AA, 16'h55, 2'd1);
	endtask
	// Erased words read back as all ones unless the protect pin guards a boot sector.
	task automatic drop(input logic [21:0] s, input bit all);
		int keys [$];
		foreach (em[i])
			if ((all || i[21:15] == s[21:15]) && (wp || (i[21:13] != 9'h000 && i[21:13] != 9'h1FF)))
				keys.push_back(i);
		foreach (keys[j])
			em.delete(keys[j]);
	endtask

	initial begin
		i_resetn = 1'b0;
		i_addr = 8'h00;
		i_wr_data = 32'h0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		void'($urandom(32'hA232E83C));
		repeat (2) @(posedge i_ref_clk);
		i_resetn <= 1'b1;
		rd(`FBH_REG_CFG, q);
		chk(q, 32'h7, "cfg reset value");
		rd(8'h20, q);
		chk(q, 32'h0, "unmapped read");
		rchk(23'h2345);
		$display("test reset done");
		for (k = 0; k < 3; k++) begin
			a = 23'($urandom_range(32'h3FDFFF, 32'h2000));
			pgm(a, 16'($urandom), 2'd2);
			rchk(a);
			rd(`FBH_REG_STATUS, q);
			chk({30'h0, q[3:2]}, {30'h0, a[21:20]}, "bank");
		end
		$display("test program done");
		for (k = 0; k < 4; k++) begin
			cfg(1'b1, k[1], 1'b1);
			a = k[0] ? 23'h3FF010 : 23'h000100;
			pgm(a, 16'($urandom), 2'd2);
			rchk(a);
		end
		$display("test protect done");
		pgm(23'h555, 16'hAA, 2'd1);
		pgm(23'h2AA, 16'h55, 2'd1);
		pgm(23'h555, 16'h20, 2'd1);
		byp = 1'b1;
		a = 23'($urandom_range(32'h3FDFFF, 32'h2000));
		pgm(a, 16'($urandom), 2'd3);
		rchk(a);
		$display("test bypass done");
		wr(`FBH_REG_CTRL, 32'h1);
		wr(`FBH_REG_CTRL, 32'h1);
		rd(`FBH_REG_STATUS, q);
		chk({30'h0, q[1:0]}, 32'h3, "go while busy");
		idle();
		wr(`FBH_REG_STATUS, 32'h2);
		cfg(1'b0, 1'b1, 1'b1);
		wr(`FBH_REG_CTRL, 32'h1);
		rd(`FBH_REG_STATUS, q);
		chk({30'h0, q[1:0]}, 32'h2, "go in flash reset");
		wr(`FBH_REG_STATUS, 32'h2);
		cfg(1'b1, 1'b1, 1'b1);
		byp = 1'b0;
		a = 23'($urandom_range(32'h3FDFFF, 32'h2000));
		pgm(a, 16'($urandom), 2'd3);
		rchk(a);
		$display("test refusal done");
		for (k = 0; k < 3; k++) begin
			ea[k] = {1'b0, 7'(k + 1), 15'($urandom)};
			pgm(ea[k], 16'($urandom) & 16'hFFFE, 2'd2);
		end
		erase_pre();
		pgm(ea[0], 16'h30, 2'd1);
		pgm(ea[1], 16'h30, 2'd1);
		drop(ea[0][21:0], 1'b0);
		drop(ea[1][21:0], 1'b0);
		for (k = 0; k < 3; k++)
			rchk(ea[k]);
		erase_pre();
		pgm(23'h555, 16'h10, 2'd1);
		drop(22'h000000, 1'b1);
		rchk(ea[2]);
		rchk(23'h000100);
		$display("test erase done");
		cfg(1'b1, 1'b1, 1'b0);
		for (k = 0; k < 2; k++) begin
			a = {22'($urandom_range(32'h3FDFFF, 32'h2000)), k[0]};
			pgm(a, 16'($urandom), 2'd2);
			rchk(a);
			rchk(a ^ 23'h1);
		end
		$display("test byte mode done");
		wrap_up();
	end
endmodule
